//--- analog_core_model.sv
/*
 * Behavioural analog comparator core with its input multiplexers, one per channel.
 * Assumes the bench supplies four levels per input side, one nibble per select code.
 */
`default_nettype none
module analog_core_model #(
	parameter bit GROUND_ON_CODE3 = 1'b0
) (
	input  wire logic                         sys_clk,
	input  wire comparator_pkg::analog_ctrl_s ctrl,
	input  wire logic [15:0]                  pos_level,
	input  wire logic [15:0]                  neg_level,
	output logic                              analog_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] vp;
	logic [3:0] vn;
	// Channel two grounds its noninverting input on code three instead of using a pin.
	assign vp = (GROUND_ON_CODE3 && ctrl.positive_input_select == 2'h3)
		? 4'h0 : pos_level[4 * ctrl.positive_input_select +: 4];
	assign vn = neg_level[4 * ctrl.negative_input_select +: 4];
	initial analog_out = 1'b0;
	// A powered-down core gives no valid answer, so it chatters rather than holding a level.
	always @(posedge sys_clk) begin
		if (ctrl.comparator_on)
			analog_out <= vp > vn;
		else
			analog_out <= ~analog_out;
	end
endmodule : analog_core_model
`default_nettype wire

//--- apb_reg_slave.sv
/*
 * APB slave front end: single-cycle access phase, write strobe and address decode helper.
 * Assumes a well-behaved APB master; pready is always high, errors are never signalled.
 */
`default_nettype none
module apb_reg_slave (
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	output logic             pready,
	output logic             pslverr,
	output logic             write_strobe,
	output logic             read_strobe,
	output logic [11:0]      word_addr
);
	assign pready       = 1'b1;
	assign pslverr      = 1'b0;
	assign write_strobe = psel & penable & pwrite;
	assign read_strobe  = psel & ~penable & ~pwrite;
	assign word_addr    = {paddr[11:2], 2'b00};
endmodule : apb_reg_slave
`default_nettype wire

//--- comparator_channel.sv
/*
 * One comparator channel: polarity, per-cycle latch, timer-clock synchroniser,
 * edge detection and the change flag.
 * Assumes the analog output and timer clock are synchronous to sys_clk.
 */
`default_nettype none
module comparator_channel (
	input  wire logic                          sys_clk,
	input  wire logic                          sys_rst,
	input  wire comparator_pkg::channel_ctrl_s ctrl,
	input  wire logic                          analog_out,
	input  wire logic                          timer_clk_prescaled,
	input  wire logic                          flag_clear,
	output logic                               comparison_result,
	output logic                               external_result,
	output logic                               comparator_change_flag
);
	logic raw_result;
	logic prev_result;
	logic sync_latch;
	logic prev_timer_clk;
	logic timer_fall;
	logic rise_event;
	logic fall_event;

	// A disabled core reads low, so toggling the polarity, or the enable while the core is high, still makes an edge.
	assign raw_result = (analog_out & ctrl.comparator_on) ^ ctrl.result_invert;
	assign timer_fall = prev_timer_clk & ~timer_clk_prescaled;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			comparison_result <= 1'b0;
			prev_result       <= 1'b0;
		end else begin
			comparison_result <= raw_result;
			prev_result       <= comparison_result;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			prev_timer_clk <= 1'b0;
			sync_latch     <= 1'b0;
		end else begin
			prev_timer_clk <= timer_clk_prescaled;
			if (timer_fall) begin
				sync_latch <= raw_result;
			end
		end
	end

	// The unsynchronised path stays combinational so the pin follows the core directly.
	assign external_result = ctrl.timer_sync_select ? sync_latch : raw_result;

	assign rise_event = ctrl.rise_flag_enable & comparison_result & ~prev_result;
	assign fall_event = ctrl.fall_flag_enable & ~comparison_result & prev_result;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			comparator_change_flag <= 1'b0;
		end else if (rise_event || fall_event) begin
			comparator_change_flag <= 1'b1;
		end else if (flag_clear) begin
			comparator_change_flag <= 1'b0;
		end
	end
endmodule : comparator_channel
`default_nettype wire

//--- comparator_checker.sv
/*
 * Port-level assertions for the dual comparator control logic, bound into its top module.
 * Assumes one clock domain and APB writes that land at the access-phase edge.
 */
`default_nettype none
module comparator_checker (
	input wire logic                         sys_clk,
	input wire logic                         sys_rst,
	input wire logic                         psel,
	input wire logic                         penable,
	input wire logic                         pwrite,
	input wire logic [11:0]                  paddr,
	input wire logic [31:0]                  pwdata,
	input wire logic                         timer_clk_prescaled,
	input wire logic [1:0]                   pin_direction_bit,
	input wire comparator_pkg::analog_ctrl_s analog_ctrl_one,
	input wire comparator_pkg::analog_ctrl_s analog_ctrl_two,
	input wire logic [1:0]                   timer_gate_result,
	input wire logic [1:0]                   result_pin_out,
	input wire logic [1:0]                   result_pin_oe_n,
	input wire logic [1:0]                   comparator_change_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	logic wr;
	logic wr_a1;
	logic wr_a2;
	logic wr_b1;
	logic clr_one;
	logic sync_on;
	assign wr = psel & penable & pwrite;
	assign wr_a1 = wr & (paddr == comparator_pkg::OFFSET_CMP1_CONTROL_A);
	assign wr_a2 = wr & (paddr == comparator_pkg::OFFSET_CMP2_CONTROL_A);
	assign wr_b1 = wr & (paddr == comparator_pkg::OFFSET_CMP1_CONTROL_B);
	assign clr_one = wr & (paddr == comparator_pkg::OFFSET_CHANGE_FLAGS) & pwdata[0];
	// The sync bit is not visible at the ports, so a shadow copy follows the writes.
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			sync_on <= 1'b0;
		else if (wr_a1)
			sync_on <= pwdata[0];
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	property p_on_write;
		wr_a1 |=> analog_ctrl_one.comparator_on == $past(pwdata[7]);
	endproperty
	a_on_write: assert property (p_on_write) else $error("enable not applied");
	property p_hyst_two;
		wr_a2 |=> analog_ctrl_two.hysteresis_on == $past(pwdata[1]);
	endproperty
	a_hyst_two: assert property (p_hyst_two) else $error("hysteresis not applied");
	property p_speed_reset;
		$past(sys_rst) |-> analog_ctrl_one.speed_power_select && !analog_ctrl_two.comparator_on;
	endproperty
	a_speed_reset: assert property (p_speed_reset) else $error("bad reset state");
	property p_sel_write;
		wr_b1 |=> analog_ctrl_one[3:0] == {$past(pwdata[5:4]), $past(pwdata[1:0])};
	endproperty
	a_sel_write: assert property (p_sel_write) else $error("select not applied");
	property p_oe_dir;
		(pin_direction_bit & ~result_pin_oe_n) == 2'h0;
	endproperty
	a_oe_dir: assert property (p_oe_dir) else $error("pin driven as input");
	property p_pin_same;
		result_pin_out == timer_gate_result;
	endproperty
	a_pin_same: assert property (p_pin_same) else $error("pin and timer differ");
	property p_sync_hold;
		(sync_on && !timer_clk_prescaled)[*4] |-> $stable(timer_gate_result[0]);
	endproperty
	a_sync_hold: assert property (p_sync_hold) else $error("sync result moved");
	property p_flag_clear;
		$fell(comparator_change_flag[0]) |-> $past(clr_one);
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag lost");
	c_flag: cover property ($rose(comparator_change_flag[0]));
	c_pin: cover property (!result_pin_oe_n[0]);
	c_sync: cover property (sync_on && $fell(timer_clk_prescaled));
endmodule : comparator_checker
bind dual_comparator_control_logic comparator_checker u_checker (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .timer_clk_prescaled(timer_clk_prescaled),
	.pin_direction_bit(pin_direction_bit), .analog_ctrl_one(analog_ctrl_one),
	.analog_ctrl_two(analog_ctrl_two), .timer_gate_result(timer_gate_result),
	.result_pin_out(result_pin_out), .result_pin_oe_n(result_pin_oe_n),
	.comparator_change_flag(comparator_change_flag));
`default_nettype wire

//--- comparator_pkg.sv
/*
 * Package for the dual comparator control logic: register offsets, field positions,
 * reset values and the carrier structs shared by the channel and the top.
 * Assumes an APB slave with 32-bit data and one aligned word per register.
 */
`default_nettype none
package comparator_pkg;

	localparam logic [11:0] OFFSET_CMP1_CONTROL_A = 12'h000;
	localparam logic [11:0] OFFSET_CMP1_CONTROL_B = 12'h004;
	localparam logic [11:0] OFFSET_CMP2_CONTROL_A = 12'h008;
	localparam logic [11:0] OFFSET_CMP2_CONTROL_B = 12'h00c;
	localparam logic [11:0] OFFSET_RESULT_MIRROR  = 12'h010;
	localparam logic [11:0] OFFSET_CHANGE_FLAGS   = 12'h014;
	localparam logic [11:0] OFFSET_PORT_CONFIG    = 12'h018;
	localparam logic [11:0] OFFSET_PORT_READ      = 12'h01c;

	localparam int BIT_ON     = 7;
	localparam int BIT_RESULT = 6;
	localparam int BIT_ROUTE  = 5;
	localparam int BIT_INVERT = 4;
	localparam int BIT_SPEED  = 2;
	localparam int BIT_HYST   = 1;
	localparam int BIT_SYNC   = 0;
	localparam int BIT_RISE   = 7;
	localparam int BIT_FALL   = 6;
	localparam int POS_SEL_LO = 4;
	localparam int NEG_SEL_LO = 0;

	localparam logic [7:0] MASK_CONTROL_A  = 8'hb7;
	localparam logic [7:0] MASK_CONTROL_B  = 8'hf3;
	localparam logic [7:0] RESET_CONTROL_A = 8'h04;
	localparam logic [7:0] RESET_CONTROL_B = 8'h00;
	localparam logic [7:0] RESET_PORT_CFG  = 8'hff;

	localparam logic [1:0] POS_DEDICATED = 2'h0;
	localparam logic [1:0] POS_DAC       = 2'h1;
	localparam logic [1:0] POS_FIXED     = 2'h2;
	localparam logic [1:0] POS_ALTERNATE = 2'h3;

	typedef struct packed {
		logic       comparator_on;
		logic       result_pin_route;
		logic       result_invert;
		logic       speed_power_select;
		logic       hysteresis_on;
		logic       timer_sync_select;
		logic       rise_flag_enable;
		logic       fall_flag_enable;
		logic [1:0] positive_input_select;
		logic [1:0] negative_input_select;
	} channel_ctrl_s;

	typedef struct packed {
		logic       comparator_on;
		logic       speed_power_select;
		logic       hysteresis_on;
		logic [1:0] positive_input_select;
		logic [1:0] negative_input_select;
	} analog_ctrl_s;

endpackage : comparator_pkg
`default_nettype wire

//--- dual_comparator_control_logic.sv
/*
 * Top of the dual comparator control logic: APB register file, two channels,
 * analog control outputs, pin routing and the port read path.
 * Assumes the analog cores, muxes, timer clock and pins sit outside, synchronous to sys_clk.
 */
`default_nettype none
module dual_comparator_control_logic (
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [1:0]  analog_out,
	input  wire logic        timer_clk_prescaled,
	input  wire logic [1:0]  pin_direction_bit,
	input  wire logic [7:0]  port_pin_level,
	output comparator_pkg::analog_ctrl_s analog_ctrl_one,
	output comparator_pkg::analog_ctrl_s analog_ctrl_two,
	output logic [1:0]      timer_gate_result,
	output logic [1:0]      result_pin_out,
	output logic [1:0]      result_pin_oe_n,
	output logic [1:0]      comparator_change_flag
);
	logic [7:0]  control_a [2];
	logic [7:0]  control_b [2];
	logic [7:0]  analog_pin_select;
	logic        write_strobe;
	logic        read_strobe;
	logic [11:0] word_addr;
	logic [1:0]  comparison_result;
	logic [1:0]  external_result;
	logic [1:0]  flag_clear;
	logic [31:0] next_prdata;
	comparator_pkg::channel_ctrl_s ctrl [2];

	function automatic comparator_pkg::channel_ctrl_s unpack_ctrl(
		input logic [7:0] reg_a,
		input logic [7:0] reg_b
	);
		comparator_pkg::channel_ctrl_s c;
		c.comparator_on         = reg_a[comparator_pkg::BIT_ON];
		c.result_pin_route      = reg_a[comparator_pkg::BIT_ROUTE];
		c.result_invert         = reg_a[comparator_pkg::BIT_INVERT];
		c.speed_power_select    = reg_a[comparator_pkg::BIT_SPEED];
		c.hysteresis_on         = reg_a[comparator_pkg::BIT_HYST];
		c.timer_sync_select     = reg_a[comparator_pkg::BIT_SYNC];
		c.rise_flag_enable      = reg_b[comparator_pkg::BIT_RISE];
		c.fall_flag_enable      = reg_b[comparator_pkg::BIT_FALL];
		c.positive_input_select = reg_b[comparator_pkg::POS_SEL_LO +: 2];
		c.negative_input_select = reg_b[comparator_pkg::NEG_SEL_LO +: 2];
		return c;
	endfunction : unpack_ctrl

	function automatic comparator_pkg::analog_ctrl_s to_analog(
		input comparator_pkg::channel_ctrl_s c
	);
		comparator_pkg::analog_ctrl_s a;
		a.comparator_on         = c.comparator_on;
		a.speed_power_select    = c.speed_power_select;
		a.hysteresis_on         = c.hysteresis_on;
		a.positive_input_select = c.positive_input_select;
		a.negative_input_select = c.negative_input_select;
		return a;
	endfunction : to_analog

	apb_reg_slave u_apb (
		.psel         (psel),
		.penable      (penable),
		.pwrite       (pwrite),
		.paddr        (paddr),
		.pready       (pready),
		.pslverr      (pslverr),
		.write_strobe (write_strobe),
		.read_strobe  (read_strobe),
		.word_addr    (word_addr)
	);

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			control_a[0] <= comparator_pkg::RESET_CONTROL_A;
			control_a[1] <= comparator_pkg::RESET_CONTROL_A;
			control_b[0] <= comparator_pkg::RESET_CONTROL_B;
			control_b[1] <= comparator_pkg::RESET_CONTROL_B;
		end else if (write_strobe) begin
			case (word_addr)
				comparator_pkg::OFFSET_CMP1_CONTROL_A: begin
					control_a[0] <= pwdata[7:0] & comparator_pkg::MASK_CONTROL_A;
				end
				comparator_pkg::OFFSET_CMP1_CONTROL_B: begin
					control_b[0] <= pwdata[7:0] & comparator_pkg::MASK_CONTROL_B;
				end
				comparator_pkg::OFFSET_CMP2_CONTROL_A: begin
					control_a[1] <= pwdata[7:0] & comparator_pkg::MASK_CONTROL_A;
				end
				comparator_pkg::OFFSET_CMP2_CONTROL_B: begin
					control_b[1] <= pwdata[7:0] & comparator_pkg::MASK_CONTROL_B;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			analog_pin_select <= comparator_pkg::RESET_PORT_CFG;
		end else if (write_strobe && word_addr == comparator_pkg::OFFSET_PORT_CONFIG) begin
			analog_pin_select <= pwdata[7:0];
		end
	end

	// Writing a one to a flag bit clears it; the channel lets a same-cycle edge win.
	assign flag_clear = (write_strobe && word_addr == comparator_pkg::OFFSET_CHANGE_FLAGS)
		? pwdata[1:0] : 2'b00;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_channel
			assign ctrl[ch] = unpack_ctrl(control_a[ch], control_b[ch]);

			comparator_channel u_channel (
				.sys_clk                (sys_clk),
				.sys_rst                (sys_rst),
				.ctrl                   (ctrl[ch]),
				.analog_out             (analog_out[ch]),
				.timer_clk_prescaled    (timer_clk_prescaled),
				.flag_clear             (flag_clear[ch]),
				.comparison_result      (comparison_result[ch]),
				.external_result        (external_result[ch]),
				.comparator_change_flag (comparator_change_flag[ch])
			);

			// Routing ignores the enable bit; a disabled core simply drives its polarity level.
			assign result_pin_out[ch]  = external_result[ch];
			assign result_pin_oe_n[ch] = ~(ctrl[ch].result_pin_route & ~pin_direction_bit[ch]);
			assign timer_gate_result[ch] = external_result[ch];
		end
	endgenerate

	// Code three of the positive select means the shared pin on channel one and
	// ground on channel two; the analog side decodes it from the channel it serves.
	assign analog_ctrl_one = to_analog(ctrl[0]);
	assign analog_ctrl_two = to_analog(ctrl[1]);

	always_comb begin
		next_prdata = 32'h0000_0000;
		case (word_addr)
			comparator_pkg::OFFSET_CMP1_CONTROL_A: begin
				next_prdata[7:0] = control_a[0];
				next_prdata[comparator_pkg::BIT_RESULT] = comparison_result[0];
			end
			comparator_pkg::OFFSET_CMP1_CONTROL_B: begin
				next_prdata[7:0] = control_b[0];
			end
			comparator_pkg::OFFSET_CMP2_CONTROL_A: begin
				next_prdata[7:0] = control_a[1];
				next_prdata[comparator_pkg::BIT_RESULT] = comparison_result[1];
			end
			comparator_pkg::OFFSET_CMP2_CONTROL_B: begin
				next_prdata[7:0] = control_b[1];
			end
			comparator_pkg::OFFSET_RESULT_MIRROR: begin
				next_prdata[1:0] = comparison_result;
			end
			comparator_pkg::OFFSET_CHANGE_FLAGS: begin
				next_prdata[1:0] = comparator_change_flag;
			end
			comparator_pkg::OFFSET_PORT_CONFIG: begin
				next_prdata[7:0] = analog_pin_select;
			end
			comparator_pkg::OFFSET_PORT_READ: begin
				next_prdata[7:0] = port_pin_level & ~analog_pin_select;
			end
			default: begin
				next_prdata = 32'h0000_0000;
			end
		endcase
	end

	// Read data is captured in the setup cycle so it is a flop during the access phase.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			prdata <= 32'h0000_0000;
		end else if (read_strobe) begin
			prdata <= next_prdata;
		end
	end
endmodule : dual_comparator_control_logic
`default_nettype wire

//--- test_dual_comparator_control_logic.sv
/*
 * Self-checking bench for the dual comparator control logic over APB.
 * Assumes the package, the design, the core model and the checker compile first.
 */
`default_nettype none
module test_dual_comparator_control_logic;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] ca1 = comparator_pkg::OFFSET_CMP1_CONTROL_A;
	localparam logic [11:0] cb1 = comparator_pkg::OFFSET_CMP1_CONTROL_B;
	localparam logic [11:0] ca2 = comparator_pkg::OFFSET_CMP2_CONTROL_A;
	localparam logic [11:0] mir = comparator_pkg::OFFSET_RESULT_MIRROR;
	localparam logic [11:0] flg = comparator_pkg::OFFSET_CHANGE_FLAGS;
	logic                         sys_clk, sys_rst, psel, penable, pwrite, tclk, pready, pslverr;
	logic [11:0]                  paddr;
	logic [31:0]                  pwdata, prdata, q;
	logic [15:0]                  pos_one, neg_one, pos_two, neg_two;
	logic [7:0]                   port_level;
	logic [1:0]                   raw, dir, tgate, pin_out, oe_n, flag;
	comparator_pkg::analog_ctrl_s ctl_one, ctl_two;
	logic [7:0]                   rv [7];
	int                           err_total = 0;
	int                           check_count = 0;
	dual_comparator_control_logic dut (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.analog_out(raw), .timer_clk_prescaled(tclk), .pin_direction_bit(dir),
		.port_pin_level(port_level), .analog_ctrl_one(ctl_one), .analog_ctrl_two(ctl_two),
		.timer_gate_result(tgate), .result_pin_out(pin_out), .result_pin_oe_n(oe_n),
		.comparator_change_flag(flag));
	analog_core_model m1 (.sys_clk(sys_clk), .ctrl(ctl_one), .pos_level(pos_one),
		.neg_level(neg_one), .analog_out(raw[0]));
	analog_core_model #(.GROUND_ON_CODE3(1'b1)) m2 (.sys_clk(sys_clk), .ctrl(ctl_two),
		.pos_level(pos_two), .neg_level(neg_two), .analog_out(raw[1]));
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16) begin
			err_total++;
			tally_and_finish();
		end
		@(posedge sys_clk);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		cyc(4);
		apb(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), q, {24'h0, e});
	endtask : rd
	task automatic t_reset_map;
		rv = '{8'h04, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'hff};
		for (int i = 0; i < 7; i++)
			rd(12'(4 * i), rv[i]);
		wr(ca1, 32'h0000000c);
		rd(ca1, 8'h04);
		wr(cb1, 32'hffffffff);
		rd(cb1, 8'hf3);
		wr(cb1, 32'h0);
		wr(12'h020, 32'hffffffff);
		rd(12'h020, 8'h00);
	endtask : t_reset_map
	task automatic t_polarity;
		logic inv;
		for (int v = 0; v < 2; v++) begin
			inv = 1'(v);
			wr(ca1, {24'h0, 3'b100, inv, 4'h0});
			wr(ca2, {24'h0, 3'b100, inv, 4'h2});
			rd(ca1, {1'b1, ~inv, 1'b0, inv, 4'h0});
			rd(ca2, {1'b1, inv, 1'b0, inv, 4'h2});
			rd(mir, {6'h0, inv, ~inv});
		end
	endtask : t_polarity
	task automatic t_select;
		logic [1:0] r;
		wr(ca1, 32'h80);
		wr(ca2, 32'h80);
		for (int k = 0; k < 4; k++) begin
			wr(cb1, 32'(k * 17));
			wr(comparator_pkg::OFFSET_CMP2_CONTROL_B, 32'(k * 17));
			r[0] = pos_one[4 * k +: 4] > neg_one[4 * k +: 4];
			r[1] = (k != 3) && (pos_two[4 * k +: 4] > neg_two[4 * k +: 4]);
			rd(mir, {6'h0, r});
		end
	endtask : t_select
	task automatic t_edges;
		wr(ca1, 32'h04);
		wr(cb1, 32'h80);
		wr(flg, 32'h3);
		wr(ca1, 32'h14);
		rd(flg, 8'h01);
		wr(flg, 32'h1);
		rd(flg, 8'h00);
		wr(ca1, 32'h04);
		rd(flg, 8'h00);
		wr(cb1, 32'h40);
		wr(ca1, 32'h14);
		rd(flg, 8'h00);
		wr(ca1, 32'h94);
		rd(flg, 8'h01);
		// Park the result low with rise detection on while the flag stays set.
		pos_one <= 16'h1a30;
		wr(ca1, 32'h80);
		wr(cb1, 32'h80);
		// The new level reaches the result bit at the setup edge of the clearing write,
		// so the rising edge and the clear meet at its access edge.
		pos_one <= 16'h1a3c;
		@(posedge sys_clk);
		wr(flg, 32'h1);
		rd(flg, 8'h01);
		wr(flg, 32'h3);
	endtask : t_edges
	task automatic t_route;
		wr(ca1, 32'h30);
		cyc(4);
		chk("pin enable", {31'h0, oe_n[0]}, 32'h0);
		chk("pin level", {31'h0, pin_out[0]}, 32'h1);
		dir <= 2'b01;
		cyc(2);
		chk("pin enable", {31'h0, oe_n[0]}, 32'h1);
		dir <= 2'b00;
		wr(ca1, 32'h10);
		cyc(2);
		chk("pin enable", {31'h0, oe_n[0]}, 32'h1);
	endtask : t_route
	task automatic t_sync;
		wr(cb1, 32'h11);
		wr(ca1, 32'h81);
		tclk <= 1'b1;
		cyc(2);
		tclk <= 1'b0;
		cyc(4);
		chk("timer result", {31'h0, tgate[0]}, 32'h0);
		tclk <= 1'b1;
		wr(cb1, 32'h00);
		cyc(4);
		chk("timer result", {31'h0, tgate[0]}, 32'h0);
		tclk <= 1'b0;
		cyc(4);
		chk("timer result", {31'h0, tgate[0]}, 32'h1);
		wr(ca1, 32'h80);
		wr(cb1, 32'h11);
		cyc(3);
		chk("timer result", {31'h0, tgate[0]}, 32'h0);
	endtask : t_sync
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	initial begin
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		tclk = 1'b0;
		dir = 2'b00;
		port_level = 8'ha5;
		pos_one = 16'h1a3c;
		neg_one = 16'h9275;
		pos_two = 16'h9275;
		neg_two = 16'h1a3c;
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'b0;
		t_reset_map();
		t_polarity();
		t_select();
		t_edges();
		t_route();
		t_sync();
		wr(12'h018, 32'h0f);
		rd(12'h01c, 8'ha0);
		tally_and_finish();
	end
endmodule : test_dual_comparator_control_logic
`default_nettype wire
